//--- rtl/dqp_pkg.sv
`default_nettype none
// ----------------------------------------------------------------------------
// Shared constants and types of the I/Q port clocking block.
// ----------------------------------------------------------------------------
package dqp_pkg;

    // System clock rate, used to turn times into cycle counts.
    localparam int unsigned CLK_MHZ       = 100;

    // Register byte offsets on the APB bus.
    localparam logic [7:0]  CTRL_OFS      = 8'h00;
    localparam logic [7:0]  RATE_OFS      = 8'h04;
    localparam logic [7:0]  REF_OFS       = 8'h08;
    localparam logic [7:0]  SKEW_OFS      = 8'h0C;
    localparam logic [7:0]  LOGIC_OFS     = 8'h10;
    localparam logic [7:0]  STAT_OFS      = 8'h14;

    // Field positions in the control word (low bit first).
    localparam int unsigned CTRL_W        = 9;
    localparam int unsigned EN_BIT        = 0;
    localparam int unsigned POL_BIT       = 1;
    localparam int unsigned PH_LSB        = 2;
    localparam int unsigned SRC_LSB       = 4;
    localparam int unsigned FMT_LSB       = 6;
    localparam int unsigned DIR_BIT       = 8;

    // Field positions in the logic type register.
    localparam int unsigned LT_LSB        = 0;
    localparam int unsigned LT_GO_BIT     = 8;

    // Field positions in the status register.
    localparam int unsigned OVF_BIT       = 0;
    localparam int unsigned UNF_BIT       = 1;
    localparam int unsigned MERR_BIT      = 2;
    localparam int unsigned REJ_BIT       = 3;
    localparam int unsigned PHE_LSB       = 4;
    localparam int unsigned SKOK_BIT      = 6;
    localparam int unsigned LED_BIT       = 7;
    localparam int unsigned DIRE_BIT      = 8;
    localparam int unsigned LTA_LSB       = 10;

    // Reset values.
    localparam logic [31:0] RATE_RST      = 32'h0001_86A0;
    localparam logic [31:0] REF_RST       = 32'h0000_2710;

    // Clock rate limits, in kHz.
    localparam logic [31:0] PH_MIN_KHZ    = 32'h0000_2710;
    localparam logic [31:0] PH_MAX_KHZ    = 32'h0003_0D40;
    localparam logic [31:0] SKEW_MIN_KHZ  = 32'h0000_61A8;
    localparam logic [31:0] SKEW_HI_KHZ   = 32'h0001_86A0;

    // Largest skew, in system clock steps, below and above the high rate.
    localparam logic [7:0]  SKEW_MAX_LO   = 8'h04;
    localparam logic [7:0]  SKEW_MAX_HI   = 8'h10;

    // Blink half period of the status indicator.
    localparam int unsigned BLINK_MS      = 250;
    localparam int unsigned BLINK_CYC     = BLINK_MS * 1000 * CLK_MHZ;

    // Clock source choices.
    typedef enum logic [1:0] {
        DQP_SRC_EXT,
        DQP_SRC_DEV,
        DQP_SRC_INT
    } dqp_src_t;

    // Transfer formats.
    typedef enum logic [1:0] {
        DQP_FMT_SER,
        DQP_FMT_PAR,
        DQP_FMT_PARI
    } dqp_fmt_t;

    // Control word as stored.
    typedef struct packed {
        logic       dir_in;
        dqp_fmt_t   fmt;
        dqp_src_t   src;
        logic [1:0] phase;
        logic       pol_neg;
        logic       en;
    } dqp_ctrl_t;

    // Sticky error flags.
    typedef struct packed {
        logic rej;
        logic merr;
        logic unf;
        logic ovf;
    } dqp_err_t;

endpackage
`default_nettype wire

//--- rtl/dqp_port_clocking.sv
// The implementer's own choices: register access over APB and the register offsets.
`default_nettype none
// Behaviour
// - clock source is external, device port or internal.
// - internal clock synthesized from reference input.
// - rate sets internal clock, else informs only.
// - coarse phase 0, 90, 180, 270 degrees.
// - 180 degrees equals negative clock polarity.
// - outside 10-200 MHz, 90 to 0, 270 to 180.
// - fine skew in steps, range depends on rate.
// - no fine skew below 25 MHz.
// - negative polarity inverts the port clock.
// - port enable starts sample transfer.
// - indicator blinks on activity, steady when idle.
// - indicator stays lit after first enable.
// - enable refused without active modulation format.
// - format dropped while enabled: disable, flag error.
// - direction selectable only with both options.
// - serial, parallel and parallel interleaved formats.
// - logic type change needs explicit confirmation.
// - settings not applicable are rejected.
// - input overflow raises error 803 flag.
// - input underflow raises error 804 flag.
module dqp_port_clocking
    import dqp_pkg::*;
#(
    parameter int unsigned DATA_W    = 16,
    parameter int unsigned DEPTH     = 16,
    parameter int unsigned BLINK_LEN = BLINK_CYC
) (
    // System clock and reset.
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // APB slave.
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Baseband side, same clock domain.
    input  wire logic              mod_active_i,
    input  wire logic              opt_out_i,
    input  wire logic              opt_in_i,
    input  wire logic [DATA_W-1:0] tx_data_i,
    output logic                   tx_take_o,
    output logic [DATA_W-1:0]      rx_data_o,
    output logic                   rx_valid_o,
    // Clock pins from outside.
    input  wire logic              ext_clk_i,
    input  wire logic              dev_clk_i,
    input  wire logic              ref_clk_i,
    // Port pins.
    output logic                   port_clk_o,
    input  wire logic [DATA_W-1:0] din_i,
    input  wire logic              din_strobe_i,
    output logic [DATA_W-1:0]      dout_o,
    output logic                   dout_oe_o,
    // Settings to the port drivers and the indicator.
    output logic [1:0]             logic_type_o,
    output logic [1:0]             format_o,
    output logic                   led_o
);

    // ------------------------------------------------------------------------
    // Parameter checks.
    // ------------------------------------------------------------------------
    initial begin
        if (DATA_W < 1 || DATA_W > 32 || DEPTH < 2 || DEPTH > 255 || BLINK_LEN < 2) begin
            $error("dqp_port_clocking: unsupported parameter value");
        end
    end

    // ------------------------------------------------------------------------
    // Pin synchronisers: two flip-flops before any logic looks.
    // ------------------------------------------------------------------------
    localparam int unsigned SW = DATA_W + 4;

    logic [SW-1:0] meta_reg;     // First stage, read only by the second.
    logic [SW-1:0] sync_reg;     // Second stage, safe to use.
    logic [SW-1:0] prev_reg;     // One more stage, for edge detection.

    // Both stages move on every edge.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= '0;
            sync_reg <= '0;
            prev_reg <= '0;
        end else begin
            meta_reg <= {din_strobe_i, din_i, ref_clk_i, dev_clk_i, ext_clk_i};
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    wire              ext_s   = sync_reg[0];
    wire              dev_s   = sync_reg[1];
    wire              ref_rise = sync_reg[2] & ~prev_reg[2];
    wire [DATA_W-1:0] din_s   = sync_reg[DATA_W+2:3];
    wire              stb_rise = sync_reg[SW-1] & ~prev_reg[SW-1];

    // ------------------------------------------------------------------------
    // Registers.
    // ------------------------------------------------------------------------
    dqp_ctrl_t   ctrl_reg;       // Port control word.
    logic [31:0] rate_reg;       // Clock rate in kHz.
    logic [31:0] ref_reg;        // Reference frequency in kHz.
    logic [7:0]  skew_reg;       // Fine skew in clock steps.
    logic [1:0]  lt_pend_reg;    // Logic type awaiting confirmation.
    logic [1:0]  lt_reg;         // Logic type in force.
    dqp_err_t    err_reg;        // Sticky error flags.
    logic        led_on_reg;     // Indicator lit since first enable.
    logic        mod_prev_reg;   // Modulation state one cycle ago.

    // Bus decode.
    wire         wr_acc  = psel & penable & pwrite;
    wire         rd_acc  = psel & penable & ~pwrite;
    wire         hit_ctl = (paddr == CTRL_OFS);
    wire         hit_rat = (paddr == RATE_OFS);
    wire         hit_ref = (paddr == REF_OFS);
    wire         hit_skw = (paddr == SKEW_OFS);
    wire         hit_lt  = (paddr == LOGIC_OFS);
    wire         hit_st  = (paddr == STAT_OFS);
    wire         mapped  = hit_ctl | hit_rat | hit_ref | hit_skw | hit_lt | hit_st;
    dqp_ctrl_t   wctrl;
    assign wctrl = dqp_ctrl_t'(pwdata[CTRL_W-1:0]);

    // Rate dependent availability.
    wire         ph_ok    = (rate_reg >= PH_MIN_KHZ) && (rate_reg <= PH_MAX_KHZ);
    wire         skew_ok  = (rate_reg >= SKEW_MIN_KHZ);
    wire [7:0]   skew_max = (rate_reg >= SKEW_HI_KHZ) ? SKEW_MAX_HI : SKEW_MAX_LO;

    // Direction is free only with both options fitted.
    wire         both_opt = opt_out_i & opt_in_i;
    wire         dir_in   = both_opt ? ctrl_reg.dir_in : (opt_in_i & ~opt_out_i);

    // Checks on a control write: undefined codes, a direction that cannot be
    // chosen, or an enable without a modulation format are refused whole.
    wire         bad_src  = (wctrl.src == 2'h3);
    wire         bad_fmt  = (wctrl.fmt == 2'h3);
    wire         bad_dir  = ~both_opt & (wctrl.dir_in != dir_in);
    wire         bad_en   = wctrl.en & ~mod_active_i;
    wire         ctl_bad  = bad_src | bad_fmt | bad_dir | bad_en;
    wire         skw_bad  = ~skew_ok | (pwdata[7:0] > skew_max) | (pwdata[31:8] != '0);
    wire         rej      = wr_acc & ((hit_ctl & ctl_bad) | (hit_skw & skw_bad));

    // Modulation format dropped while the port is on.
    wire         mod_drop = ctrl_reg.en & mod_prev_reg & ~mod_active_i;

    // Zero wait state slave; errors on unmapped or refused accesses.
    assign pready  = 1'b1;
    assign pslverr = psel & penable & (~mapped | rej);

    // Control register write and automatic disable.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg     <= '0;
            mod_prev_reg <= 1'b0;
        end else begin
            mod_prev_reg <= mod_active_i;
            if (wr_acc && hit_ctl && !ctl_bad) begin
                ctrl_reg <= wctrl;
            end
            if (mod_drop) begin
                ctrl_reg.en <= 1'b0;
            end
        end
    end

    // Rate, reference and skew settings.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rate_reg <= RATE_RST;
            ref_reg  <= REF_RST;
            skew_reg <= '0;
        end else begin
            if (wr_acc && hit_rat) begin
                rate_reg <= pwdata;
            end
            if (wr_acc && hit_ref) begin
                ref_reg <= pwdata;
            end
            if (wr_acc && hit_skw && !skw_bad) begin
                skew_reg <= pwdata[7:0];
            end
        end
    end

    // Logic type: a write only stages it, the confirm bit makes it real.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lt_pend_reg <= '0;
            lt_reg      <= '0;
        end else if (wr_acc && hit_lt) begin
            lt_pend_reg <= pwdata[LT_LSB+1:LT_LSB];
            if (pwdata[LT_GO_BIT]) begin
                lt_reg <= lt_pend_reg;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Internal clock: accumulator stepped on reference edges keeps it locked.
    // ------------------------------------------------------------------------
    logic [32:0] acc_reg;        // Phase accumulator.
    logic        int_clk_reg;    // Synthesized clock level.
    wire  [32:0] acc_sum = acc_reg + {rate_reg, 1'b0};

    // Each rising reference edge adds twice the rate; passing the reference
    // frequency toggles the clock, so it runs at rate * fref / ref.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acc_reg     <= '0;
            int_clk_reg <= 1'b0;
        end else if (ctrl_reg.src == DQP_SRC_INT && ref_rise) begin
            if (acc_sum >= {1'b0, ref_reg}) begin
                acc_reg     <= acc_sum - {1'b0, ref_reg};
                int_clk_reg <= ~int_clk_reg;
            end else begin
                acc_reg <= acc_sum;
            end
        end
    end

    // Source selection; the external pin is ignored while internal is used.
    logic src_lvl;
    always_comb begin
        unique case (ctrl_reg.src)
            DQP_SRC_EXT: src_lvl = ext_s;
            DQP_SRC_DEV: src_lvl = dev_s;
            DQP_SRC_INT: src_lvl = int_clk_reg;
            default:     src_lvl = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------------
    // Phase, polarity and skew.
    // ------------------------------------------------------------------------
    logic        src_prev_reg;   // Source level one cycle ago.
    logic [15:0] per_cnt_reg;    // Cycles since the last rising edge.
    logic [15:0] per_reg;        // Last measured source period.
    logic [15:0] dly_reg;        // Cycles left before the pending edge.
    logic        pend_reg;       // An edge is waiting to be shown.
    logic        plvl_reg;       // Level that the pending edge brings.
    logic        dlvl_reg;       // Delayed source level.

    wire         src_edge = src_lvl ^ src_prev_reg;
    wire         src_rise = src_lvl & ~src_prev_reg;
    wire  [1:0]  ph_eff   = ph_ok ? ctrl_reg.phase : {ctrl_reg.phase[1], 1'b0};
    wire         invert   = ctrl_reg.pol_neg ^ ph_eff[1];
    wire  [15:0] quarter  = ph_eff[0] ? {2'b00, per_reg[15:2]} : 16'h0000;
    wire  [7:0]  skew_eff = skew_ok ? skew_reg : 8'h00;
    wire  [15:0] dly_load = quarter + {8'h00, skew_eff};

    // Period meter and delay of each source edge by quarter plus skew.
    // A new edge arriving before the last is shown replaces it, so very
    // large skews at high rates collapse rather than pile up.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            src_prev_reg <= 1'b0;
            per_cnt_reg  <= '0;
            per_reg      <= '0;
            dly_reg      <= '0;
            pend_reg     <= 1'b0;
            plvl_reg     <= 1'b0;
            dlvl_reg     <= 1'b0;
        end else begin
            src_prev_reg <= src_lvl;
            if (src_rise) begin
                per_cnt_reg <= 16'h0001;
                per_reg     <= per_cnt_reg;
            end else if (per_cnt_reg != 16'hFFFF) begin
                per_cnt_reg <= per_cnt_reg + 16'h0001;
            end
            if (src_edge && dly_load == 16'h0000) begin
                dlvl_reg <= src_lvl;
                pend_reg <= 1'b0;
            end else if (src_edge) begin
                dly_reg  <= dly_load - 16'h0001;
                plvl_reg <= src_lvl;
                pend_reg <= 1'b1;
            end else if (pend_reg && dly_reg == 16'h0000) begin
                dlvl_reg <= plvl_reg;
                pend_reg <= 1'b0;
            end else if (pend_reg) begin
                dly_reg <= dly_reg - 16'h0001;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Port clock and data movement.
    // ------------------------------------------------------------------------
    logic       pclk_reg;        // Port clock as driven.
    logic       pclk_prev_reg;   // Port clock one cycle ago.
    wire        word_edge = pclk_reg & ~pclk_prev_reg;

    // Inversion moves each word start onto the falling edge of the source.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pclk_reg      <= 1'b0;
            pclk_prev_reg <= 1'b0;
        end else begin
            pclk_reg      <= dlvl_reg ^ invert;
            pclk_prev_reg <= pclk_reg;
        end
    end

    assign port_clk_o   = pclk_reg;
    assign tx_take_o    = ctrl_reg.en & dout_oe_o & word_edge;
    assign logic_type_o = lt_reg;
    assign format_o     = ctrl_reg.fmt;

    // Output words leave on each port clock word edge while enabled in the output direction.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dout_o    <= '0;
            dout_oe_o <= 1'b0;
        end else begin
            dout_oe_o <= ctrl_reg.en & ~dir_in;
            if (tx_take_o) begin
                dout_o <= tx_data_i;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Input rate tracking: strobes fill, clock edges drain.
    // ------------------------------------------------------------------------
    logic [7:0] lvl_reg;         // Samples waiting at the configured rate.
    wire        in_run  = ctrl_reg.en & dir_in;
    wire        fill    = in_run & stb_rise;
    wire        drain   = in_run & word_edge;
    wire        ovf_ev  = fill & ~drain & (lvl_reg == 8'(DEPTH));
    wire        unf_ev  = drain & ~fill & (lvl_reg == 8'h00);

    // The level is only a rate gauge; the sample itself is passed straight on.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lvl_reg    <= '0;
            rx_data_o  <= '0;
            rx_valid_o <= 1'b0;
        end else begin
            rx_valid_o <= drain & (lvl_reg != 8'h00 || fill);
            if (drain) begin
                rx_data_o <= din_s;
            end
            if (!in_run) begin
                lvl_reg <= '0;
            end else if (fill && !drain && !ovf_ev) begin
                lvl_reg <= lvl_reg + 8'h01;
            end else if (drain && !fill && !unf_ev) begin
                lvl_reg <= lvl_reg - 8'h01;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Sticky errors: write one to clear; a new event wins over the clear.
    // ------------------------------------------------------------------------
    wire [3:0] clr = (wr_acc && hit_st) ? pwdata[REJ_BIT:OVF_BIT] : 4'h0;
    wire [3:0] set = {rej, mod_drop, unf_ev, ovf_ev};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            err_reg <= '0;
        end else begin
            err_reg <= dqp_err_t'(set | (err_reg & ~clr));
        end
    end

    // ------------------------------------------------------------------------
    // Status indicator.
    // ------------------------------------------------------------------------
    logic [31:0] blink_cnt_reg;  // Cycles into the current blink half.
    logic        blink_reg;      // Blink phase.
    logic        act_reg;        // Data lines toggled in this half.
    logic        act_seen_reg;   // Activity found in the last half.
    logic [DATA_W-1:0] lines_prev_reg;
    wire  [DATA_W-1:0] lines = dir_in ? din_s : dout_o;
    wire         toggled = (lines != lines_prev_reg);
    wire         half_end = (blink_cnt_reg == 32'(BLINK_LEN - 1));

    // Activity is judged over a whole blink half so a short burst still shows.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            blink_cnt_reg  <= '0;
            blink_reg      <= 1'b0;
            act_reg        <= 1'b0;
            act_seen_reg   <= 1'b0;
            lines_prev_reg <= '0;
            led_on_reg     <= 1'b0;
            led_o          <= 1'b0;
        end else begin
            lines_prev_reg <= lines;
            if (ctrl_reg.en) begin
                led_on_reg <= 1'b1;
            end
            if (half_end) begin
                blink_cnt_reg <= '0;
                blink_reg     <= ~blink_reg;
                act_seen_reg  <= act_reg | toggled;
                act_reg       <= 1'b0;
            end else begin
                blink_cnt_reg <= blink_cnt_reg + 32'h0000_0001;
                act_reg       <= act_reg | toggled;
            end
            led_o <= led_on_reg & (~act_seen_reg | blink_reg);
        end
    end

    // ------------------------------------------------------------------------
    // Read data.
    // ------------------------------------------------------------------------
    wire [31:0] stat = {20'h0_0000, lt_reg, 1'b0, dir_in, led_on_reg, skew_ok,
                        ph_eff, err_reg};
    wire [31:0] ctl_rd = {23'h00_0000, dir_in, ctrl_reg[CTRL_W-2:0]};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prdata <= '0;
        end else if (psel && !penable && !pwrite) begin
            prdata <= hit_ctl ? ctl_rd :
                      hit_rat ? rate_reg :
                      hit_ref ? ref_reg :
                      hit_skw ? {24'h00_0000, skew_reg} :
                      hit_lt  ? {30'h0000_0000, lt_pend_reg} :
                      hit_st  ? stat : 32'h0000_0000;
        end
    end

endmodule
`default_nettype wire

//--- test/dqp_port_clocking_assertions.sv
`default_nettype none
// Ties bus refusals, port enable and word hand-off to their causes.
module dqp_chk
    import dqp_pkg::*;
#(parameter int unsigned DATA_W = 16) (
    // Clock, reset and the watched ports.
    input wire logic              clk_i, rst_i, psel, penable, pwrite, pslverr,
    input wire logic              mod_active_i, tx_take_o, dout_oe_o, led_o,
    input wire logic [7:0]        paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [DATA_W-1:0] tx_data_i, dout_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire  wr_w = psel && penable && pwrite; // Write taken at this edge.
    logic seen_reg;                         // Port switched on since reset.
    // Notes an accepted enable: a lit indicator needs one.
    always_ff @(posedge clk_i) seen_reg <= !rst_i && (seen_reg || (wr_w &&
        paddr == CTRL_OFS && pwdata[EN_BIT] && !pslverr));
    a_led_after_en: assert property (led_o |-> seen_reg) else $error("lit");
    a_take_enabled: assert property (tx_take_o |-> dout_oe_o) else $error("take");
    a_word_sent: assert property (tx_take_o |=> dout_o == $past(tx_data_i))
        else $error("word");
    a_drop_off: assert property ($fell(mod_active_i) && dout_oe_o |-> ##[1:4] !dout_oe_o)
        else $error("drop");
    a_en_mod: assert property ($rose(dout_oe_o) |-> $past(mod_active_i))
        else $error("mod");
    a_err_access: assert property (pslverr |-> psel && penable) else $error("err");
    a_unmapped_err: assert property (psel && penable && paddr > STAT_OFS |-> pslverr)
        else $error("map");
    a_skew_bits: assert property (wr_w && paddr == SKEW_OFS && |pwdata[31:8] |-> pslverr)
        else $error("skew");
    a_bad_code: assert property (wr_w && paddr == CTRL_OFS &&
        (&pwdata[5:4] || &pwdata[7:6]) |-> pslverr) else $error("code");
endmodule
bind dqp_port_clocking dqp_chk #(.DATA_W(DATA_W)) u_chk (.clk_i, .rst_i, .psel, .penable,
    .pwrite, .pslverr, .mod_active_i, .tx_take_o, .dout_oe_o, .led_o, .paddr, .pwdata,
    .tx_data_i, .dout_o);
`default_nettype wire

//--- test/dqp_dev_model.sv
`default_nettype none
// Far-side device: clock only inside frames, one word per 80 ns.
module dqp_dev_model (
    input  wire logic        run_i,
    input  wire logic        push_i,
    output var  logic        dev_clk_o = 1'b0,
    output var  logic        strobe_o = 1'b0,
    output var  logic [15:0] din_o = 16'h0000
);
    timeunit 1ns;
    timeprecision 1ps;
    // The clock parks low between frames, as a real source would.
    always #40 dev_clk_o = run_i & ~dev_clk_o;
    // Every line flips each 40 ns step, so the lines change every step but each 80 ns word repeats the one before.
    always #40 begin
        strobe_o = push_i & ~strobe_o;
        din_o = ~din_o;
    end
endmodule
`default_nettype wire

//--- test/testbench.sv
`default_nettype none
// Drives bus and pins; reads checked against queued notes.
module testbench;
    import dqp_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 1'b0, ref_clk = 1'b0, ext_clk = 1'b0; // Ext pin idle
    logic        rst_i = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        mod = 1'b0, run = 1'b0, push = 1'b0, pready, pslverr, dclk, strb;
    logic [7:0]  paddr = 8'h00;
    logic [15:0] tx = 16'h0000, din;
    logic [31:0] pwdata = 32'h0000_0000, prdata, qe[$], qm[$];
    int          n_mismatch = 0, total_checks = 0;
    dqp_port_clocking #(.BLINK_LEN(8)) dut (.clk_i, .rst_i, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .mod_active_i(mod), .opt_out_i(1'b1),
        .opt_in_i(1'b1), .tx_data_i(tx), .tx_take_o(), .rx_data_o(), .rx_valid_o(),
        .ext_clk_i(ext_clk), .dev_clk_i(dclk), .ref_clk_i(ref_clk), .port_clk_o(),
        .din_i(din), .din_strobe_i(strb), .dout_o(), .dout_oe_o(), .logic_type_o(),
        .format_o(), .led_o());
    dqp_dev_model far (.run_i(run), .push_i(push), .dev_clk_o(dclk), .strobe_o(strb),
        .din_o(din));
    initial forever #5 clk_i = ~clk_i;
    initial forever #40 ref_clk = ~ref_clk;
    // Watchdog: a hang counts as a mismatch.
    initial begin
        #100us;
        n_mismatch++;
        final_report();
    end
    // Random samples from one fixed seed.
    initial begin
        void'($urandom(84));
        forever @(posedge clk_i) tx <= 16'($urandom);
    end
    // Each read answer retires the oldest note.
    always @(posedge clk_i)
        if (psel && penable && !pwrite && pready === 1'b1)
            chk(prdata, qe.pop_front(), qm.pop_front());
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input logic [31:0] m);
        total_checks++;
        if ((g & m) !== (e & m)) begin
            n_mismatch++;
            $display("unexpected at %0t: read %h want %h", $time, g, e);
        end
    endtask
    task automatic final_report();
        if (n_mismatch == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // One APB transfer, held until pready is high.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge clk_i);
        penable <= 1'b1;
        do @(posedge clk_i); while (pready !== 1'b1);
        {psel, penable} <= 2'b00;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        qe.push_back(e);
        qm.push_back(m);
        apb(1'b0, a, 32'h0000_0000);
    endtask
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(RATE_OFS, RATE_RST, '1);
        rd(REF_OFS, REF_RST, '1);
        rd(8'h40, 32'h0000_0000, '1);
        apb(1'b1, CTRL_OFS, 32'h0000_0021);
        rd(STAT_OFS, 32'h0000_0008, 32'h0000_0088);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, RATE_OFS, i[1] ? 32'h0001_86A0 : 32'h0003_0D41);
            apb(1'b1, CTRL_OFS, i[0] ? 32'h0000_002C : 32'h0000_0024);
            rd(STAT_OFS, {25'h0, 1'b1, i[0], i[1], 4'h0}, 32'h0000_0070);
        end
        apb(1'b1, RATE_OFS, 32'h0000_4E20);
        apb(1'b1, SKEW_OFS, 32'h0000_0001);
        rd(SKEW_OFS, 32'h0000_0000, '1);
        apb(1'b1, RATE_OFS, 32'h0001_86A0);
        apb(1'b1, SKEW_OFS, 32'h0000_0010);
        apb(1'b1, SKEW_OFS, 32'h0000_0011);
        rd(SKEW_OFS, 32'h0000_0010, '1);
        apb(1'b1, RATE_OFS, 32'h0000_30D4);
        apb(1'b1, STAT_OFS, 32'h0000_000F);
        mod <= 1'b1;
        apb(1'b1, CTRL_OFS, 32'h0000_0021);
        repeat (100) @(posedge clk_i);
        rd(CTRL_OFS, 32'h0000_0021, 32'h0000_01FF);
        rd(STAT_OFS, 32'h0000_0080, 32'h0000_018F);
        mod <= 1'b0;
        repeat (4) @(posedge clk_i);
        rd(CTRL_OFS, 32'h0000_0000, 32'h0000_0001);
        rd(STAT_OFS, 32'h0000_0084, 32'h0000_0084);
        mod <= 1'b1;
        apb(1'b1, CTRL_OFS, 32'h0000_0101);
        push <= 1'b1;
        repeat (300) @(posedge clk_i);
        push <= 1'b0;
        rd(STAT_OFS, 32'h0000_0001, 32'h0000_0001);
        apb(1'b1, STAT_OFS, 32'h0000_0001);
        rd(STAT_OFS, 32'h0000_0000, 32'h0000_0001);
        apb(1'b1, CTRL_OFS, 32'h0000_0191);
        rd(CTRL_OFS, 32'h0000_0191, 32'h0000_01FF);
        run <= 1'b1;
        repeat (400) @(posedge clk_i);
        run <= 1'b0;
        rd(STAT_OFS, 32'h0000_0002, 32'h0000_0002);
        apb(1'b1, LOGIC_OFS, 32'h0000_0002);
        rd(STAT_OFS, 32'h0000_0000, 32'h0000_0C00);
        apb(1'b1, LOGIC_OFS, 32'h0000_0100);
        rd(STAT_OFS, 32'h0000_0800, 32'h0000_0C00);
        final_report();
    end
endmodule
`default_nettype wire
